// file: core_model.sv
module core_model (
	// Clock
	input wire logic clk,
	// Core requests
	output logic halt_exec,
	output logic int_req,
	output logic core_masked,
	output logic [2:0] irq_enable
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		halt_exec = 1'b0;
		int_req = 1'b0;
		core_masked = 1'b0;
		irq_enable = 3'h0;
	end

	// safe entry
	// Watchdog and bus release are never enabled here, so every halt is a legal entry
	task halt();
		halt_exec <= 1'b1;
		@(posedge clk);
		halt_exec <= 1'b0;
		@(posedge clk);
	endtask

	task set(input logic r, input logic m, input logic [2:0] e);
		int_req <= r;
		core_masked <= m;
		irq_enable <= e;
	endtask
endmodule

// file: pdc_pkg.sv
package pdc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFF_MSTBY = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SYSCTL = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DIVCTL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

	localparam logic [7:0] MSTBY_RESET = 8'h00;
	localparam int BIT_T16 = 4;
	localparam int BIT_T8A = 3;
	localparam int BIT_T8B = 2;
	localparam int BIT_ADC = 0;

	localparam int SYS_DEEP_BIT = 7;
	localparam int SYS_WAIT_LSB = 4;
	localparam int SYS_NMIEDGE_BIT = 3;
	localparam logic [2:0] WAIT_RESET = 3'h0;
	localparam logic [2:0] WAIT_SHORT = 3'h6;
	localparam logic [2:0] WAIT_ILLEGAL = 3'h7;
	localparam logic [1:0] DIV_RESET = 2'h0;

	localparam int BASE_STATES = 8192;
	localparam int SHORT_STATES = 1024;
	localparam int CNT_W = 19;
	localparam logic [7:0] PERIPH_IDLE_READ = 8'hff;

	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_SLEEP = 6'h02,
		ST_SWSTBY = 6'h04,
		ST_SETTLE = 6'h08,
		ST_RESET = 6'h10,
		ST_HWSTBY = 6'h20
	} pd_state_t;

endpackage

// file: power_down_mode_controller.sv
// Added by the designer: the APB register port and the register offsets.
module power_down_mode_controller
	import pdc_pkg::*;
#(
	parameter int SETTLE_BASE_STATES = BASE_STATES,
	parameter int SETTLE_SHORT_STATES = SHORT_STATES
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	output logic [DATA_W-1:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Processor core
	input wire logic HALT_EXEC,
	input wire logic INT_REQ,
	input wire logic CORE_MASKED,
	input wire logic [2:0] IRQ_ENABLE,
	// Pins
	input wire logic CHIP_INIT_IN_N,
	input wire logic HW_STANDBY_IN_N,
	input wire logic NMI_IN,
	input wire logic [2:0] IRQ_IN_N,
	// Power state outputs
	output logic CORE_HALT,
	output logic CLOCK_RUN,
	output logic PERIPH_HALT,
	output logic PERIPH_RESET,
	output logic PORT_HOLD,
	output logic PORT_HIZ,
	output logic HW_STANDBY_ACT,
	output logic INT_EXC_START,
	output logic RESET_EXC_START,
	// Module standby outputs
	output logic TIMER16_STANDBY,
	output logic TIMER8_CH01_STANDBY,
	output logic TIMER8_CH23_STANDBY,
	output logic ADC_STANDBY,
	output logic [1:0] CLOCK_DIVIDE
);

	// The longest wait code must still fit the settle counter
	if (SETTLE_BASE_STATES < 1 || SETTLE_SHORT_STATES < 1) begin
		$error("settle lengths must be positive");
	end
	if ((SETTLE_BASE_STATES << 5) > (1 << CNT_W) || SETTLE_SHORT_STATES > (1 << CNT_W)) begin
		$error("settle lengths exceed the settle counter");
	end

	// Pin synchronisers
	logic init_n_s1_q;
	logic init_n_s2_q;
	logic hwstby_n_s1_q;
	logic hwstby_n_s2_q;
	logic nmi_s1_q;
	logic nmi_s2_q;
	logic nmi_prev_q;
	logic [2:0] irq_n_s1_q;
	logic [2:0] irq_n_s2_q;

	// Idle levels at reset, so no false edge or wake follows reset
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			init_n_s1_q <= 1'b1;
			init_n_s2_q <= 1'b1;
			hwstby_n_s1_q <= 1'b1;
			hwstby_n_s2_q <= 1'b1;
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
			nmi_prev_q <= 1'b0;
			irq_n_s1_q <= 3'h7;
			irq_n_s2_q <= 3'h7;
		end else begin
			init_n_s1_q <= CHIP_INIT_IN_N;
			init_n_s2_q <= init_n_s1_q;
			hwstby_n_s1_q <= HW_STANDBY_IN_N;
			hwstby_n_s2_q <= hwstby_n_s1_q;
			nmi_s1_q <= NMI_IN;
			nmi_s2_q <= nmi_s1_q;
			nmi_prev_q <= nmi_s2_q;
			irq_n_s1_q <= IRQ_IN_N;
			irq_n_s2_q <= irq_n_s1_q;
		end
	end

	// Registers
	logic [7:0] mstby_q;
	logic deep_q;
	logic [2:0] wait_q;
	logic nmi_edge_sel_q;
	logic [1:0] div_q;
	pd_state_t state_q;
	pd_state_t state_d;

	settle_if sif ();

	settle_timer #(
		.BASE_LEN(SETTLE_BASE_STATES),
		.SHORT_LEN(SETTLE_SHORT_STATES)
	) i_settle_timer (
		.clk(CORE_CLK),
		.rst(RST),
		.sif(sif)
	);

	// APB decode
	logic acc;
	logic wr_fire;
	logic regs_init;
	logic map_hit;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFF_MSTBY) || (a == OFF_SYSCTL) || (a == OFF_DIVCTL) || (a == OFF_STATUS);
	endfunction

	function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a);
		logic [DATA_W-1:0] w;
		w = '0;
		unique case (a)
			OFF_MSTBY: w[7:0] = mstby_q;
			OFF_SYSCTL: begin
				w[SYS_DEEP_BIT] = deep_q;
				w[SYS_WAIT_LSB +: 3] = wait_q;
				w[SYS_NMIEDGE_BIT] = nmi_edge_sel_q;
			end
			OFF_DIVCTL: w[1:0] = div_q;
			OFF_STATUS: begin
				w[5:0] = state_q;
				w[8] = sif.busy;
			end
			default: w = '0;
		endcase
		return w;
	endfunction

	assign acc = PSEL && PENABLE;
	// Unmapped offsets answer with an error and never write
	assign map_hit = addr_mapped(PADDR);
	// One wait state: the answer comes from flip-flops, so the write lands at the completing edge
	assign wr_fire = acc && PREADY && PWRITE && map_hit;
	// chip reset and hardware standby reinitialise
	assign regs_init = !init_n_s2_q || (state_q == ST_HWSTBY) || !hwstby_n_s2_q;

	// The second access edge sees PREADY high and closes the transfer
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end else if (acc && !PREADY) begin
			PREADY <= 1'b1;
			PRDATA <= PWRITE ? '0 : read_word(PADDR);
			PSLVERR <= !map_hit;
		end else begin
			PREADY <= 1'b0;
			PRDATA <= '0;
			PSLVERR <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			mstby_q <= MSTBY_RESET;
		end else if (regs_init) begin
			mstby_q <= MSTBY_RESET;
		end else if (wr_fire && PADDR == OFF_MSTBY) begin
			mstby_q <= PWDATA[7:0];
		end
	end

	// System control fields
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			deep_q <= 1'b0;
			wait_q <= WAIT_RESET;
			nmi_edge_sel_q <= 1'b0;
		end else if (regs_init) begin
			deep_q <= 1'b0;
			wait_q <= WAIT_RESET;
			nmi_edge_sel_q <= 1'b0;
		end else if (wr_fire && PADDR == OFF_SYSCTL) begin
			deep_q <= PWDATA[SYS_DEEP_BIT];
			nmi_edge_sel_q <= PWDATA[SYS_NMIEDGE_BIT];
			if (PWDATA[SYS_WAIT_LSB +: 3] != WAIT_ILLEGAL)
				wait_q <= PWDATA[SYS_WAIT_LSB +: 3];
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			div_q <= DIV_RESET;
		end else if (regs_init) begin
			div_q <= DIV_RESET;
		end else if (wr_fire && PADDR == OFF_DIVCTL) begin
			div_q <= PWDATA[1:0];
		end
	end

	// Wake sources
	logic nmi_edge;
	logic sleep_wake;
	logic sw_wake;

	assign nmi_edge = nmi_edge_sel_q ? (nmi_s2_q && !nmi_prev_q) : (!nmi_s2_q && nmi_prev_q);
	assign sleep_wake = nmi_edge || (INT_REQ && !CORE_MASKED);
	assign sw_wake = nmi_edge || ((|(~irq_n_s2_q & IRQ_ENABLE)) && !CORE_MASKED);

	// Mode sequencer
	always_comb begin
		state_d = state_q;
		sif.start = 1'b0;
		// Pins come first: a wake in the same cycle as a pin event is dropped
		if (!hwstby_n_s2_q) begin
			state_d = ST_HWSTBY;
		end else if (!init_n_s2_q) begin
			state_d = ST_RESET;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					if (HALT_EXEC) begin
						state_d = deep_q ? ST_SWSTBY : ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (sleep_wake)
						state_d = ST_RUN;
				end
				ST_SWSTBY: begin
					if (sw_wake) begin
						state_d = ST_SETTLE;
						sif.start = 1'b1;
					end
				end
				ST_SETTLE: begin
					if (sif.done)
						state_d = ST_RUN;
				end
				ST_RESET: state_d = ST_RUN;
				// Hardware standby is always left through the reset state
				ST_HWSTBY: state_d = ST_RESET;
				default: state_d = ST_RESET;
			endcase
		end
	end

	// The timer latches code and divide at start, so a later write cannot stretch a wait
	assign sif.code = wait_q;
	assign sif.div = div_q;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Exception start pulses
	// One cycle wide, so the core enters each handler once
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			INT_EXC_START <= 1'b0;
			RESET_EXC_START <= 1'b0;
		end else begin
			INT_EXC_START <= (state_d == ST_RUN) && (state_q == ST_SLEEP || state_q == ST_SETTLE);
			RESET_EXC_START <= (state_d == ST_RUN) && (state_q == ST_RESET);
		end
	end

	// Software standby and its settle wait share one output pattern
	function automatic logic in_deep(input pd_state_t s);
		return (s == ST_SWSTBY) || (s == ST_SETTLE);
	endfunction

	// Power state outputs follow the next state so they line up with it
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			CORE_HALT <= 1'b0;
			CLOCK_RUN <= 1'b1;
			PERIPH_HALT <= 1'b0;
			PERIPH_RESET <= 1'b0;
			PORT_HOLD <= 1'b0;
			PORT_HIZ <= 1'b0;
			HW_STANDBY_ACT <= 1'b0;
		end else begin
			CORE_HALT <= (state_d != ST_RUN);
			CLOCK_RUN <= (state_d == ST_RUN) || (state_d == ST_SLEEP) || (state_d == ST_RESET);
			PERIPH_HALT <= in_deep(state_d) || (state_d == ST_HWSTBY);
			PERIPH_RESET <= in_deep(state_d) || (state_d == ST_HWSTBY) || (state_d == ST_RESET);
			PORT_HOLD <= in_deep(state_d);
			PORT_HIZ <= (state_d == ST_HWSTBY);
			HW_STANDBY_ACT <= (state_d == ST_HWSTBY);
		end
	end

	// Module standby outputs: a standby peripheral reads all ones and drops writes
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			TIMER16_STANDBY <= 1'b0;
			TIMER8_CH01_STANDBY <= 1'b0;
			TIMER8_CH23_STANDBY <= 1'b0;
			ADC_STANDBY <= 1'b0;
			CLOCK_DIVIDE <= DIV_RESET;
		end else begin
			TIMER16_STANDBY <= mstby_q[BIT_T16];
			TIMER8_CH01_STANDBY <= mstby_q[BIT_T8A];
			TIMER8_CH23_STANDBY <= mstby_q[BIT_T8B];
			ADC_STANDBY <= mstby_q[BIT_ADC];
			CLOCK_DIVIDE <= div_q;
		end
	end

endmodule

// file: power_down_mode_controller_properties.sv
module power_down_mode_controller_properties
	import pdc_pkg::*;
(
	// Clock, reset, pins
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic CHIP_INIT_IN_N,
	input wire logic HW_STANDBY_IN_N,
	// APB
	input wire logic PWRITE,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [ADDR_W-1:0] PADDR,
	input wire logic [DATA_W-1:0] PWDATA,
	input wire logic [DATA_W-1:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Power state
	input wire logic CORE_HALT,
	input wire logic CLOCK_RUN,
	input wire logic HW_STANDBY_ACT,
	input wire logic INT_EXC_START,
	input wire logic RESET_EXC_START,
	input wire logic TIMER16_STANDBY,
	input wire logic ADC_STANDBY
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_t16_rise;
		$rose(TIMER16_STANDBY) |-> $past(PREADY && PWRITE && PADDR == OFF_MSTBY && PWDATA[BIT_T16], 2);
	endproperty
	a_t16_rise: assert property (p_t16_rise) else $error("timer16 standby rose without write");
	property p_adc_rise;
		$rose(ADC_STANDBY) |-> $past(PREADY && PWRITE && PADDR == OFF_MSTBY && PWDATA[BIT_ADC], 2);
	endproperty
	a_adc_rise: assert property (p_adc_rise) else $error("adc standby rose without write");
	property p_ready_pulse;
		PREADY |=> !PREADY;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
	property p_one_wait;
		PSEL && PENABLE && !PREADY |=> PREADY;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("no answer after one wait");
	property p_err_data;
		PREADY && PSLVERR |-> PRDATA == '0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("error answer carries data");
	property p_int_exc;
		INT_EXC_START |-> !CORE_HALT ##1 !INT_EXC_START;
	endproperty
	a_int_exc: assert property (p_int_exc) else $error("interrupt start while halted");
	property p_hw_enter;
		!HW_STANDBY_IN_N [*6] |-> HW_STANDBY_ACT;
	endproperty
	a_hw_enter: assert property (p_hw_enter) else $error("standby pin ignored");
	property p_clk_stop;
		!CLOCK_RUN |-> CORE_HALT || HW_STANDBY_ACT || !CHIP_INIT_IN_N;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("clock stopped with core running");
	property p_reset_exc;
		$rose(CHIP_INIT_IN_N) |-> ##[1:6] RESET_EXC_START;
	endproperty
	a_reset_exc: assert property (p_reset_exc) else $error("no reset start after pin rise");
	property p_keep_mstby;
		!CLOCK_RUN && HW_STANDBY_IN_N && CHIP_INIT_IN_N |=> $stable(TIMER16_STANDBY);
	endproperty
	a_keep_mstby: assert property (p_keep_mstby) else $error("standby bit lost in deep standby");

	c_int: cover property (INT_EXC_START);
	c_rst: cover property (RESET_EXC_START);
	c_hw: cover property (HW_STANDBY_ACT);
endmodule

bind power_down_mode_controller power_down_mode_controller_properties i_props (.CORE_CLK, .RST,
	.CHIP_INIT_IN_N, .HW_STANDBY_IN_N, .PWRITE, .PSEL, .PENABLE, .PADDR, .PWDATA, .PRDATA, .PREADY,
	.PSLVERR, .CORE_HALT, .CLOCK_RUN, .HW_STANDBY_ACT, .INT_EXC_START, .RESET_EXC_START,
	.TIMER16_STANDBY, .ADC_STANDBY);

// file: power_down_mode_controller_tb_top.sv
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module power_down_mode_controller_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import pdc_pkg::*;
	// Short settle counts keep the run brief
	localparam int BASE = 8;
	localparam int SHORT = 2;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic init_n = 1'b1, hw_standby_in_n_n = 1'b1, nmi = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [2:0] irq_n = 3'h7, irq_en;
	logic pready, pslverr, er, halt, int_req, masked;
	logic core_halt, clk_run, p_halt, p_rst, p_hold, p_hiz, hw_act, int_exc, rst_exc;
	logic s16, s01, s23, sadc;
	logic [1:0] cdiv;
	logic [3:0] ev;
	int error_cnt = 0, checks = 0;
	assign ev = {hw_act, rst_exc, int_exc, core_halt};

	initial begin
		forever #50 clk = ~clk;
	end

	core_model i_core_model (.clk(clk), .halt_exec(halt), .int_req(int_req), .core_masked(masked),
		.irq_enable(irq_en));

	power_down_mode_controller #(.SETTLE_BASE_STATES(BASE), .SETTLE_SHORT_STATES(SHORT))
	i_power_down_mode_controller (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .HALT_EXEC(halt), .INT_REQ(int_req), .CORE_MASKED(masked),
		.IRQ_ENABLE(irq_en), .CHIP_INIT_IN_N(init_n), .HW_STANDBY_IN_N(hw_standby_in_n_n), .NMI_IN(nmi),
		.IRQ_IN_N(irq_n), .CORE_HALT(core_halt), .CLOCK_RUN(clk_run), .PERIPH_HALT(p_halt),
		.PERIPH_RESET(p_rst), .PORT_HOLD(p_hold), .PORT_HIZ(p_hiz), .HW_STANDBY_ACT(hw_act),
		.INT_EXC_START(int_exc), .RESET_EXC_START(rst_exc), .TIMER16_STANDBY(s16),
		.TIMER8_CH01_STANDBY(s01), .TIMER8_CH23_STANDBY(s23), .ADC_STANDBY(sadc), .CLOCK_DIVIDE(cdiv));

	task finish_test();
		if (error_cnt == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wait_ev(input int k, input int lim, output int n);
		n = 0;
		while (ev[k] !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > lim) begin
				error_cnt++;
				finish_test();
			end
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task t_regs();
		apb(1'b0, OFF_MSTBY, 32'h0);
		`CHK(rd[7:0], MSTBY_RESET)
		apb(1'b0, 8'h10, 32'h0);
		`CHK(er, 1'b1)
		apb(1'b1, OFF_MSTBY, 32'h1d);
		@(posedge clk);
		`CHK({s16, s01, s23, sadc}, 4'hf)
		apb(1'b1, OFF_MSTBY, 32'he2);
		apb(1'b0, OFF_MSTBY, 32'h0);
		`CHK(rd[7:0], 8'he2)
		`CHK({s16, s01, s23, sadc}, 4'h0)
	endtask

	task t_sleep();
		int n;
		apb(1'b1, OFF_SYSCTL, 32'h0);
		i_core_model.set(1'b0, 1'b1, 3'h0);
		i_core_model.halt();
		i_core_model.set(1'b1, 1'b1, 3'h0);
		repeat (5) @(posedge clk);
		`CHK({core_halt, clk_run}, 2'h3)
		`CHK(p_halt, 1'b0)
		i_core_model.set(1'b1, 1'b0, 3'h0);
		wait_ev(1, 10, n);
		`CHK(core_halt, 1'b0)
		i_core_model.set(1'b0, 1'b0, 3'h0);
		@(posedge clk);
		nmi <= 1'b1;
		repeat (4) @(posedge clk);
		i_core_model.set(1'b1, 1'b1, 3'h0);
		i_core_model.halt();
		repeat (4) @(posedge clk);
		`CHK(core_halt, 1'b1)
		nmi <= 1'b0;
		wait_ev(1, 10, n);
		`CHK(core_halt, 1'b0)
		i_core_model.set(1'b0, 1'b0, 3'h0);
		@(posedge clk);
	endtask

	task t_swstby();
		logic [2:0] c;
		int n, len;
		apb(1'b1, OFF_DIVCTL, 32'h1);
		apb(1'b1, OFF_MSTBY, 32'h10);
		for (int i = 0; i < 2; i++) begin
			c = i ? WAIT_SHORT : WAIT_RESET;
			len = (i ? SHORT : BASE) * 2;
			// software picks wait code and divide; short counts stand in for the real minimum
			apb(1'b1, OFF_SYSCTL, {24'h0, 1'b1, c, 4'h8});
			apb(1'b1, OFF_SYSCTL, 32'hf8);
			apb(1'b0, OFF_SYSCTL, 32'h0);
			`CHK(rd[6:4], c)
			i_core_model.set(1'b0, i ? 1'b1 : 1'b0, i ? 3'h1 : 3'h0);
			i_core_model.halt();
			irq_n <= 3'h6;
			repeat (6) @(posedge clk);
			`CHK({clk_run, p_halt, p_rst, p_hold}, 4'h7)
			if (i) begin
				nmi <= 1'b1;
			end else begin
				i_core_model.set(1'b0, 1'b0, 3'h1);
			end
			wait_ev(1, 100, n);
			`CHK(n >= len && n <= len + 8, 1'b1)
			irq_n <= 3'h7;
			nmi <= 1'b0;
			apb(1'b0, OFF_SYSCTL, 32'h0);
			`CHK(rd[7], 1'b1)
			apb(1'b0, OFF_MSTBY, 32'h0);
			`CHK(rd[7:0], 8'h10)
		end
		`CHK(cdiv, 2'h1)
	endtask

	task t_pins();
		int n;
		apb(1'b1, OFF_MSTBY, 32'h11);
		apb(1'b1, OFF_SYSCTL, 32'h0);
		i_core_model.halt();
		init_n <= 1'b0;
		repeat (4) @(posedge clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		`CHK(rd[5:0], 6'h10)
		`CHK({s16, sadc}, 2'h0)
		init_n <= 1'b1;
		wait_ev(2, 10, n);
		apb(1'b1, OFF_SYSCTL, 32'h80);
		i_core_model.halt();
		init_n <= 1'b0;
		repeat (5) @(posedge clk);
		`CHK({clk_run, core_halt}, 2'h3)
		init_n <= 1'b1;
		wait_ev(2, 10, n);
		`CHK(core_halt, 1'b0)
		apb(1'b1, OFF_MSTBY, 32'h11);
		apb(1'b1, OFF_SYSCTL, 32'h80);
		i_core_model.halt();
		hw_standby_in_n_n <= 1'b0;
		wait_ev(3, 10, n);
		`CHK(p_hiz, 1'b1)
		init_n <= 1'b0;
		repeat (3) @(posedge clk);
		hw_standby_in_n_n <= 1'b1;
		repeat (3) @(posedge clk);
		init_n <= 1'b1;
		wait_ev(2, 10, n);
		apb(1'b0, OFF_MSTBY, 32'h0);
		`CHK(rd[7:0], MSTBY_RESET)
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_sleep();
		t_swstby();
		t_pins();
		finish_test();
	end
endmodule

// file: settle_if.sv
interface settle_if;
	logic start;
	logic [2:0] code;
	logic [1:0] div;
	logic done;
	logic busy;
	modport ctrl (output start, output code, output div, input done, input busy);
	modport timer (input start, input code, input div, output done, output busy);
endinterface

// file: settle_timer.sv
module settle_timer
	import pdc_pkg::*;
#(
	parameter int BASE_LEN = BASE_STATES,
	parameter int SHORT_LEN = SHORT_STATES
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control side
	settle_if.timer sif
);

	if (BASE_LEN < 1 || SHORT_LEN < 1 || (BASE_LEN << 5) > (1 << CNT_W) || SHORT_LEN > (1 << CNT_W)) begin
		$error("settle lengths out of range");
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] len_q;
	logic [2:0] pre_q;
	logic [1:0] div_q;
	logic busy_q;
	logic done_q;
	logic tick;

	function automatic logic [CNT_W-1:0] state_len(input logic [2:0] code);
		if (code == WAIT_SHORT)
			return CNT_W'(SHORT_LEN - 1);
		return CNT_W'((BASE_LEN << code) - 1);
	endfunction

	function automatic logic [2:0] div_mask(input logic [1:0] div);
		return 3'((1 << div) - 1);
	endfunction

	assign tick = (pre_q == div_mask(div_q));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pre_q <= 3'h0;
		end else if (sif.start || tick) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= pre_q + 3'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			len_q <= '0;
			div_q <= DIV_RESET;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (sif.start) begin
				cnt_q <= '0;
				len_q <= state_len(sif.code);
				div_q <= sif.div;
				busy_q <= 1'b1;
			end else if (busy_q && tick) begin
				if (cnt_q == len_q) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q + CNT_W'(1);
				end
			end
		end
	end

	assign sif.done = done_q;
	assign sif.busy = busy_q;

endmodule
